// [dadi_host.sv]
`timescale 1ns/1ps
module dadi_host (
  input wire logic ref_clk,
  input wire logic par_mode,
  input wire logic sdo_oe,
  output logic cs_n,
  output logic sck,
  output logic sdi,
  output logic sdo_i
);
  logic pd0_r = 1'h0;
  // In serial mode the pull-up holds the line high unless the device pulls it low; in parallel mode pd0_r drives it.
  assign sdo_i = par_mode ? pd0_r : !sdo_oe;
  initial begin
    cs_n = 1'h1;
    sck = 1'h0;
    sdi = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // With sel low the clock still toggles but the select stays high.
  task automatic frame(input logic sel, input logic [15:0] w, output logic [7:0] rd);
    rd = 8'h00;
    cs_n <= !sel;
    for (int i = 15; i >= 0; i--) begin
      sdi <= w[i];
      tick(4);
      sck <= 1'h1;
      tick(4);
      if (i < 8) rd[i] = sdo_i;
      sck <= 1'h0;
    end
    tick(4);
    cs_n <= 1'h1;
    sdi <= !sdi;
    tick(4);
  endtask
  task automatic pins(input logic c, input logic s, input logic d, input logic o);
    cs_n <= c;
    sck <= s;
    sdi <= d;
    pd0_r <= o;
  endtask
endmodule

// [dadi_pkg.sv]
package dadi_pkg;
  // APB register byte offsets.
  localparam logic [7:0] DADI_CTRL_OFS = 8'h00;
  localparam logic [7:0] DADI_STATUS_OFS = 8'h04;
  localparam logic [7:0] DADI_INT_EN_OFS = 8'h08;
  localparam logic [7:0] DADI_INT_CLR_OFS = 8'h0c;
  localparam logic [7:0] DADI_MODE_VIEW_OFS = 8'h10;
  // Control register fields and reset value.
  localparam int DADI_CTRL_CONV_EN_BIT = 0;
  localparam logic [31:0] DADI_CTRL_RST = 32'h0000_0001;
  // Event bits shared by status, enable and clear registers.
  localparam int DADI_EV_SER_WR_BIT = 0;
  localparam int DADI_EV_SER_RD_BIT = 1;
  localparam int DADI_EV_CH1_OVR_BIT = 2;
  localparam int DADI_EV_CH2_OVR_BIT = 3;
  localparam int DADI_EV_W = 4;
  localparam logic [3:0] DADI_INT_EN_RST = 4'h0;
  // Mode view register fields.
  localparam int DADI_VIEW_PHASE_LSB = 0;
  localparam int DADI_VIEW_DCS_BIT = 2;
  localparam int DADI_VIEW_OMODE_BIT = 3;
  localparam int DADI_VIEW_PD_LSB = 4;
  localparam int DADI_VIEW_STRAP_BIT = 6;
  // Serial frame: read flag, 7 address bits, 8 data bits.
  localparam int DADI_SER_FRAME_BITS = 16;
  localparam int DADI_SER_HDR_BITS = 8;
  localparam logic [4:0] DADI_SER_HDR_CNT = 5'd8;
  localparam logic [4:0] DADI_SER_END_CNT = 5'd16;
  // Mode register indices and fields.
  localparam int DADI_MODE_REGS = 4;
  localparam logic [1:0] DADI_MR_PHASE = 2'd0;
  localparam logic [1:0] DADI_MR_DCS = 2'd1;
  localparam logic [1:0] DADI_MR_OMODE = 2'd2;
  localparam logic [1:0] DADI_MR_PD = 2'd3;
  localparam logic [7:0] DADI_MR_RST = 8'h00;
  // Sample pipeline depth in encode cycles.
  localparam int DADI_PIPE_LAT = 6;
  localparam int DADI_PHASE_W = 2;
endpackage

// [dadi_top.sv]
// Chosen here: the APB slave port and the address map.
`timescale 1ns/1ps
module dadi_top
  import dadi_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int LATENCY = DADI_PIPE_LAT
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic prog_mode_strap,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo_i,
  output logic sdo_o,
  output logic sdo_oe,
  input wire logic encode_clk_pos,
  input wire logic encode_clk_neg,
  input wire logic [DATA_W-1:0] ch_one_conv,
  input wire logic [DATA_W-1:0] ch_two_conv,
  input wire logic ch_one_ovr,
  input wire logic ch_two_ovr,
  output logic [DATA_W-1:0] ch_one_sample_bus,
  output logic [DATA_W-1:0] ch_two_sample_bus,
  output logic ch_one_range_flag,
  output logic ch_two_range_flag,
  output logic fwd_out_clk_pos,
  output logic fwd_out_clk_neg,
  output logic dcs_en,
  output logic out_mode,
  output logic [1:0] power_down
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: strap, select, clock, data in, data out, encode pair.
  logic [6:0] meta_r;
  logic [6:0] sync_r;
  logic [6:0] last_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meta_r <= 7'h00;
      sync_r <= 7'h00;
      last_r <= 7'h00;
    end else begin
      meta_r <= {prog_mode_strap, cs_n, sck, sdi, sdo_i, encode_clk_pos, encode_clk_neg};
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  logic strap_s;
  logic cs_n_s;
  logic sck_s;
  logic sdi_s;
  logic sdo_s;
  logic enc_lvl;
  logic enc_prev;
  logic sck_rise;
  logic sck_fall;
  logic enc_rise;

  assign strap_s = sync_r[6];
  assign cs_n_s = sync_r[5];
  assign sck_s = sync_r[4];
  assign sdi_s = sync_r[3];
  assign sdo_s = sync_r[2];
  // Differential encode: high when positive leg above negative leg.
  assign enc_lvl = sync_r[1] & ~sync_r[0];
  assign enc_prev = last_r[1] & ~last_r[0];
  assign sck_rise = sck_s & ~last_r[4];
  assign sck_fall = ~sck_s & last_r[4];
  assign enc_rise = enc_lvl & ~enc_prev;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial mode port.
  logic ser_act;
  logic [4:0] bit_cnt_r;
  logic [15:0] shift_r;
  logic [7:0] rd_shift_r;
  logic rd_frame_r;
  logic [7:0] mode_r [DADI_MODE_REGS];
  logic ser_wr_ev;
  logic ser_rd_ev;

  assign ser_act = ~strap_s & ~cs_n_s;
  assign ser_wr_ev = ser_act & sck_rise & (bit_cnt_r == DADI_SER_END_CNT - 5'd1) &
                     ~shift_r[DADI_SER_FRAME_BITS-2];
  assign ser_rd_ev = ser_act & sck_rise & (bit_cnt_r == DADI_SER_END_CNT - 5'd1) &
                     rd_frame_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bit_cnt_r <= 5'd0;
      shift_r <= 16'h0000;
    end else if (!ser_act) begin
      bit_cnt_r <= 5'd0;
    end else if (sck_rise && bit_cnt_r != DADI_SER_END_CNT) begin
      shift_r <= {shift_r[14:0], sdi_s};
      bit_cnt_r <= bit_cnt_r + 5'd1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_frame_r <= 1'b0;
    end else if (!ser_act) begin
      rd_frame_r <= 1'b0;
    end else if (sck_rise && bit_cnt_r == DADI_SER_HDR_CNT - 5'd1) begin
      rd_frame_r <= shift_r[DADI_SER_HDR_BITS-2];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < DADI_MODE_REGS; i++) begin
        mode_r[i] <= DADI_MR_RST;
      end
    end else if (ser_wr_ev) begin
      mode_r[shift_r[8:7]] <= {shift_r[6:0], sdi_s};
    end
  end

  // Readback word is loaded once the header is in and shifted out on falls.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_shift_r <= 8'h00;
      sdo_oe <= 1'b0;
    end else if (!ser_act) begin
      sdo_oe <= 1'b0;
    end else if (sck_rise && bit_cnt_r == DADI_SER_HDR_CNT - 5'd1) begin
      // The last address bit is still on the data pin at the eighth rise.
      rd_shift_r <= mode_r[{shift_r[0], sdi_s}];
    end else if (sck_fall && rd_frame_r && bit_cnt_r >= DADI_SER_HDR_CNT &&
                 bit_cnt_r < DADI_SER_END_CNT) begin
      sdo_oe <= ~rd_shift_r[7];
      rd_shift_r <= {rd_shift_r[6:0], 1'b0};
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sdo_o <= 1'b0;
    end else begin
      sdo_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Effective operating mode from the registers or from the static pins.
  logic [DADI_PHASE_W-1:0] phase_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dcs_en <= 1'b0;
      out_mode <= 1'b0;
      power_down <= 2'b00;
      phase_r <= '0;
    end else if (strap_s) begin
      dcs_en <= cs_n_s;
      out_mode <= sck_s;
      power_down <= {sdi_s, sdo_s};
      phase_r <= '0;
    end else begin
      dcs_en <= mode_r[DADI_MR_DCS][0];
      out_mode <= mode_r[DADI_MR_OMODE][0];
      power_down <= mode_r[DADI_MR_PD][1:0];
      phase_r <= mode_r[DADI_MR_PHASE][DADI_PHASE_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sample pipeline, both channels and flags on one encode edge.
  logic [31:0] ctrl_r;
  logic conv_go;
  logic [DATA_W-1:0] pipe1_r [LATENCY];
  logic [DATA_W-1:0] pipe2_r [LATENCY];
  logic [LATENCY-1:0] ovr1_r;
  logic [LATENCY-1:0] ovr2_r;
  logic upd_r;

  assign conv_go = enc_rise & ctrl_r[DADI_CTRL_CONV_EN_BIT] & (power_down == 2'b00);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe1_r[i] <= '0;
        pipe2_r[i] <= '0;
      end
      ovr1_r <= '0;
      ovr2_r <= '0;
    end else if (conv_go) begin
      pipe1_r[0] <= ch_one_conv;
      pipe2_r[0] <= ch_two_conv;
      ovr1_r <= {ovr1_r[LATENCY-2:0], ch_one_ovr};
      ovr2_r <= {ovr2_r[LATENCY-2:0], ch_two_ovr};
      for (int i = 1; i < LATENCY; i++) begin
        pipe1_r[i] <= pipe1_r[i-1];
        pipe2_r[i] <= pipe2_r[i-1];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ch_one_sample_bus <= '0;
      ch_two_sample_bus <= '0;
      ch_one_range_flag <= 1'b0;
      ch_two_range_flag <= 1'b0;
      upd_r <= 1'b0;
    end else begin
      upd_r <= conv_go;
      if (conv_go) begin
        ch_one_sample_bus <= pipe1_r[LATENCY-1];
        ch_two_sample_bus <= pipe2_r[LATENCY-1];
        ch_one_range_flag <= ovr1_r[LATENCY-1];
        ch_two_range_flag <= ovr2_r[LATENCY-1];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Forwarded clock: inverted encode level, optionally delayed.
  logic [3:0] enc_dly_r;
  logic [4:0] enc_tap;

  assign enc_tap = {enc_dly_r, enc_lvl};

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      enc_dly_r <= 4'h0;
    end else begin
      enc_dly_r <= {enc_dly_r[2:0], enc_lvl};
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      fwd_out_clk_pos <= 1'b1;
      fwd_out_clk_neg <= 1'b0;
    end else begin
      fwd_out_clk_pos <= ~enc_tap[phase_r];
      fwd_out_clk_neg <= enc_tap[phase_r];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave with event status, enable and clear registers.
  logic [DADI_EV_W-1:0] status_r;
  logic [DADI_EV_W-1:0] int_en_r;
  logic [DADI_EV_W-1:0] ev_set;
  logic [DADI_EV_W-1:0] ev_clr;
  logic [DADI_EV_W-1:0] int_en_nxt;
  logic wr_acc;

  assign wr_acc = psel & penable & pready & pwrite;
  assign ev_set = {conv_go & ovr2_r[LATENCY-1], conv_go & ovr1_r[LATENCY-1],
                   ser_rd_ev, ser_wr_ev};
  assign ev_clr = (wr_acc && paddr == DADI_INT_CLR_OFS) ? pwdata[DADI_EV_W-1:0] : '0;
  assign int_en_nxt = (wr_acc && paddr == DADI_INT_EN_OFS) ? pwdata[DADI_EV_W-1:0] :
                      int_en_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~(paddr inside {DADI_CTRL_OFS, DADI_STATUS_OFS,
                 DADI_INT_EN_OFS, DADI_INT_CLR_OFS, DADI_MODE_VIEW_OFS});
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          DADI_CTRL_OFS: prdata <= ctrl_r;
          DADI_STATUS_OFS: prdata <= {28'h0, status_r};
          DADI_INT_EN_OFS: prdata <= {28'h0, int_en_r};
          DADI_MODE_VIEW_OFS: prdata <= {25'h0, strap_s, power_down, out_mode, dcs_en,
                                         phase_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= DADI_CTRL_RST;
      int_en_r <= DADI_INT_EN_RST;
    end else if (wr_acc && paddr == DADI_CTRL_OFS) begin
      ctrl_r <= {31'h0, pwdata[DADI_CTRL_CONV_EN_BIT]};
    end else if (wr_acc && paddr == DADI_INT_EN_OFS) begin
      int_en_r <= pwdata[DADI_EV_W-1:0];
    end
  end

  // A set arriving with its clear wins.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      status_r <= '0;
      irq <= 1'b0;
    end else begin
      status_r <= (status_r & ~ev_clr) | ev_set;
      // The next enable is used so that the line never lags an enable write.
      irq <= |(((status_r & ~ev_clr) | ev_set) & int_en_nxt);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  ser_idle_hold_a: assert property ((strap_s || cs_n_s) |=> bit_cnt_r == 5'd0)
    else $error("serial counter moved while deselected");
  ser_write_take_a: assert property (ser_wr_ev |=> mode_r[$past(shift_r[8:7])] ==
                                     {$past(shift_r[6:0]), $past(sdi_s)})
    else $error("serial write not stored");
  sdo_drive_only_a: assert property (sdo_oe |-> !sdo_o && $past(ser_act) &&
                                     $past(rd_frame_r))
    else $error("readback pin driven outside readback");
  sdo_fall_only_a: assert property ($rose(sdo_oe) |-> $past(sck_fall))
    else $error("readback bit changed off a falling edge");
  par_dcs_pin_a: assert property (strap_s && $stable(strap_s)
                                  |=> dcs_en == $past(cs_n_s))
    else $error("stabilizer not following select pin");
  par_omode_pin_a: assert property (strap_s && $stable(strap_s)
                                    |=> out_mode == $past(sck_s))
    else $error("output mode not following clock pin");
  par_pd_pins_a: assert property (strap_s ##1 strap_s |-> power_down ==
                                  $past({sdi_s, sdo_s}))
    else $error("power state not following data pins");
  data_on_enc_a: assert property ($changed(ch_one_sample_bus) |-> $past(conv_go))
    else $error("sample changed without encode edge");
  clk_fall_data_a: assert property (conv_go && phase_r == 2'd0 |=> !fwd_out_clk_pos)
    else $error("forwarded clock not low with new data");
  clk_phase_dly_a: assert property (enc_rise && phase_r == 2'd2 && $stable(phase_r)
                                    |-> fwd_out_clk_pos ##2 fwd_out_clk_pos ##1 !fwd_out_clk_pos)
    else $error("forwarded clock phase delay wrong");
  clk_compl_a: assert property (fwd_out_clk_neg == !fwd_out_clk_pos)
    else $error("complement clock not inverse");
  flag_with_word_a: assert property ($changed(ch_two_range_flag) |-> upd_r)
    else $error("flag changed outside data update");
  chan_pair_a: assert property ($changed(ch_two_sample_bus) |-> upd_r)
    else $error("channel two word changed alone");
  irq_level_a: assert property (|(status_r & int_en_r) |-> irq)
    else $error("interrupt low with enabled event");

  ser_write_c: cover property (ser_wr_ev);
  ser_read_c: cover property (ser_rd_ev ##[1:40] !ser_act);
  ovr_flag_c: cover property ($rose(ch_one_range_flag));
  par_mode_c: cover property (strap_s && power_down != 2'b00);

endmodule

// [testbench.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  import dadi_pkg::*;
  logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, irq, strap, enc;
  logic cs_n, sck, sdi, sdo_i, sdo_o, sdo_oe, f1, f2, of1, of2, fp, fn, fpq;
  logic dcs_en, omode, run, chk, err;
  logic [1:0] pd;
  logic [5:0] ench = 6'h00;
  logic [7:0] paddr, srd;
  logic [15:0] c1, c2, o1, o2, o1q;
  logic [31:0] pwdata, prdata, q;
  logic [7:0] mexp [4] = '{8'h02, 8'h01, 8'h01, 8'h02};
  int num_errors = 0, checks_done = 0, cyc = 0, k = 0, ph = 0, tph = 0;
  dadi_top dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .prog_mode_strap(strap), .cs_n(cs_n), .sck(sck),
    .sdi(sdi), .sdo_i(sdo_i), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .encode_clk_pos(enc),
    .encode_clk_neg(!enc), .ch_one_conv(c1), .ch_two_conv(c2), .ch_one_ovr(f1),
    .ch_two_ovr(f2), .ch_one_sample_bus(o1), .ch_two_sample_bus(o2),
    .ch_one_range_flag(of1), .ch_two_range_flag(of2), .fwd_out_clk_pos(fp),
    .fwd_out_clk_neg(fn), .dcs_en(dcs_en), .out_mode(omode), .power_down(pd));
  dadi_host host (.ref_clk(ref_clk), .par_mode(strap), .sdo_oe(sdo_oe), .cs_n(cs_n),
    .sck(sck), .sdi(sdi), .sdo_i(sdo_i));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] w1(int n);
    return 16'h8001 + 16'(n) * 16'h0123;
  endfunction
  function automatic logic [15:0] w2(int n);
    return 16'h7ffe - 16'(n) * 16'h0321;
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge ref_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic x);
    apb(1'h0, a, 32'h0);
    `CHK(q, e)
    `CHK(err, x)
  endtask
  task automatic irqc(input logic e);
    repeat (2) @(posedge ref_clk);
    `CHK(irq, e)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = !ref_clk;
  end
  initial begin
    wait (cyc == 20000);
    num_errors++;
    results();
  end
  // Encode clock of 400 ns period; the core words change while it is low.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    ph <= (ph + 1) % 4;
    ench <= {ench[4:0], enc};
    o1q <= o1;
    fpq <= fp;
    if (run && ph == 3) begin
      enc <= !enc;
      if (enc) begin
        k <= k + 1;
        c1 <= w1(k + 1);
        c2 <= w2(k + 1);
        f1 <= 1'((k + 1) % 2);
        f2 <= ((k + 1) % 3 == 0);
      end else if (chk && k >= 8) begin
        `CHK(o1, w1(k - 7))
        `CHK(o2, w2(k - 7))
        `CHK(of1, 1'((k - 7) % 2))
        `CHK(of2, ((k - 7) % 3 == 0))
      end
    end
    // The forwarded clock is the inverted encode pin three edges late, plus the phase delay.
    if (run) begin
      `CHK(fn, !fp)
      `CHK(fp, !ench[2 + tph])
    end
    if (chk && o1 !== o1q) begin
      `CHK({fpq, fp}, 2'h2)
    end
    if (run && !chk) begin
      `CHK(o1, o1q)
    end
  end
  initial begin
    reset = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    strap = 1'h0;
    enc = 1'h0;
    run = 1'h0;
    chk = 1'h0;
    c1 = w1(0);
    c2 = w2(0);
    f1 = 1'h0;
    f2 = 1'h1;
    repeat (6) @(posedge ref_clk);
    reset <= 1'h0;
    @(posedge ref_clk);
    rdc(DADI_CTRL_OFS, DADI_CTRL_RST, 1'h0);
    rdc(DADI_STATUS_OFS, 32'h0, 1'h0);
    rdc(8'h14, 32'h0, 1'h1);
    run <= 1'h1;
    chk <= 1'h1;
    repeat (176) @(posedge ref_clk);
    run <= 1'h0;
    chk <= 1'h0;
    rdc(DADI_STATUS_OFS, 32'hc, 1'h0);
    apb(1'h1, DADI_INT_EN_OFS, 32'h4);
    irqc(1'h1);
    apb(1'h1, DADI_INT_EN_OFS, 32'h0);
    irqc(1'h0);
    apb(1'h1, DADI_INT_EN_OFS, 32'h4);
    apb(1'h1, DADI_INT_CLR_OFS, 32'hc);
    irqc(1'h0);
    rdc(DADI_INT_CLR_OFS, 32'h0, 1'h0);
    host.frame(1'h1, 16'h0201, srd);
    `CHK(omode, 1'h1)
    host.frame(1'h1, 16'h0302, srd);
    `CHK(pd, 2'h2)
    host.frame(1'h1, 16'h0101, srd);
    host.frame(1'h1, 16'h0002, srd);
    host.frame(1'h0, 16'h0200, srd);
    `CHK(omode, 1'h1)
    for (int i = 0; i < 4; i++) begin
      host.frame(1'h1, {1'h1, 7'(i), 8'h00}, srd);
      `CHK(srd, mexp[i])
    end
    `CHK(sdo_i, 1'h1)
    `CHK(sdo_o, 1'h0)
    rdc(DADI_MODE_VIEW_OFS, 32'h2e, 1'h0);
    rdc(DADI_STATUS_OFS, 32'h3, 1'h0);
    // Phase two with power-down set: the clock lags and the words hold.
    tph <= 2;
    run <= 1'h1;
    repeat (48) @(posedge ref_clk);
    run <= 1'h0;
    strap <= 1'h1;
    for (int i = 0; i < 4; i++) begin
      host.pins(!i[0], i[1] ^ i[0], i[1], i[0]);
      repeat (8) @(posedge ref_clk);
      `CHK(dcs_en, !i[0])
      `CHK(omode, i[1] ^ i[0])
      `CHK(pd, 2'(i))
      rdc(DADI_MODE_VIEW_OFS, {25'h0, 1'h1, 2'(i), i[1] ^ i[0], !i[0], 2'h0}, 1'h0);
    end
    results();
  end
endmodule
